// ### rtl/pdc_decoder.sv
// Programmable address decoder with two product-term arrays and port routing.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Both arrays share one identical input vector; don't-care inputs never matter.
// - Upper pin as power-down and high deselects all outputs; else extra input.
// - Reset forces all decoder outputs deselected; reset is never a term input.
// - Array A gives eight bank selects, each one product term.
// - Array A gives one SRAM select from one product term.
// - Array A gives a port block select from one product term.
// - Track mode: track-in select with read drives Port A onto low host pins.
// - Track mode: address-out select with ALE drives low host address to Port A.
// - Track mode: data-out select drives host data to Port A; else Port A floats.
// - Chip selects 0 to 3 each OR four programmable AND terms.
// - Chip selects 4 to 7 each OR two programmable AND terms.
// - Port C pins choose address input A16-A18 or one-term chip select 8-10.
// - Width setting 0 is 8 bit, 1 is 16; mux setting 0 is non-multiplexed.
// - Latch strobe polarity 0 is active high, 1 is active low.
// - Multiplexed: track setting 1 tracks; else each Port A pin is I/O or latched address.
// - A16-A19 transparent with latch setting 0, captured by ALE with 1.
// - Non-multiplexed A0-A15 transparent with option 0, ALE-dependent with 1.
// - Strobe style 00 read/write pulses, 01 status with E, 11 status with DS.
// - Port B pin outputs its chip select with setting 0, I/O with 1.
// - 16-bit non-multiplexed: Port A low data byte, Port B high byte.
// - Configuration is fixed input only; no read or write path exists.
// - Multiplexed address is captured at the trailing edge of ALE.
module pdc_decoder
	import pdc_pkg::*;
(
	input wire logic mclk_in, // 250 MHz clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic pad_reset_n_in, // device reset pin, active low
	input wire pdc_cfg_t cfg_in, // fixed configuration bits
	input wire pdc_term_t [PDC_NTERMS-1:0] terms_in, // programmed product terms
	input wire logic ale_in, // address latch strobe pin
	input wire logic rd_e_in, // read, enable or data strobe pin
	input wire logic wr_rw_in, // write or read/write pin
	input wire logic upper_pin_in, // power-down select or A19 pin
	input wire logic [PDC_PAGE_BITS-1:0] page_inputs_in, // page number inputs
	input wire logic [7:0] ad_lo_in, // host AD0-AD7 level
	input wire logic [7:0] ad_hi_in, // host AD8-AD15 level
	input wire logic [7:0] porta_in, // Port A pin level
	input wire logic [7:0] portb_in, // Port B pin level
	input wire logic [2:0] portc_in, // Port C pin level
	input wire logic [7:0] porta_gpio_dout_in, // Port A data register
	input wire logic [7:0] porta_gpio_dir_in, // Port A direction register
	input wire logic [7:0] portb_gpio_dout_in, // Port B data register
	input wire logic [7:0] portb_gpio_dir_in, // Port B direction register
	input wire logic [15:0] bus_rdata_in, // data from the selected internal block
	output logic [PDC_NBANK-1:0] bank_selects_n_out, // program memory bank selects
	output logic sram_select_n_out, // data SRAM select
	output logic port_block_select_n_out, // port register block select
	output logic [PDC_NCS_B-1:0] portb_chip_selects_n_out, // chip selects 0-7
	output logic [PDC_NCS_C-1:0] portc_chip_selects_n_out, // chip selects 8-10
	output logic standby_out, // decoder in power-down
	output logic host_read_out, // internal read strobe decoded
	output logic host_write_out, // internal write strobe decoded
	output logic [15:0] bus_wdata_out, // host write data
	output logic [19:0] addr_out, // effective host address
	output logic [7:0] ad_lo_out, // host AD0-AD7 drive
	output logic [7:0] ad_lo_oe_out, // host AD0-AD7 enable
	output logic [7:0] ad_hi_out, // host AD8-AD15 drive
	output logic [7:0] ad_hi_oe_out, // host AD8-AD15 enable
	output logic [7:0] porta_out, // Port A drive
	output logic [7:0] porta_oe_out, // Port A enable
	output logic [7:0] portb_out, // Port B drive
	output logic [7:0] portb_oe_out, // Port B enable
	output logic [2:0] portc_out, // Port C drive
	output logic [2:0] portc_oe_out // Port C enable
);

	// ==========================================================
	// Strobes and address latch
	// ==========================================================
	// strobe polarity
	wire logic ale_act = ale_in ^ cfg_in.latch_strobe_polarity_cfg;
	wire logic mux_mode = cfg_in.bus_mux_cfg;
	wire logic wide = cfg_in.bus_width_cfg;
	logic rd_act;
	logic wr_act;

	always_comb begin
		case (cfg_in.strobe_style_cfg)
			PDC_STROBE_RDWR: begin
				rd_act = ~rd_e_in;
				wr_act = ~wr_rw_in;
			end
			PDC_STROBE_E: begin
				rd_act = rd_e_in & wr_rw_in;
				wr_act = rd_e_in & ~wr_rw_in;
			end
			PDC_STROBE_DS: begin
				rd_act = ~rd_e_in & wr_rw_in;
				wr_act = ~rd_e_in & ~wr_rw_in;
			end
			default: begin
				rd_act = 1'b0;
				wr_act = 1'b0;
			end
		endcase
	end

	logic [15:0] lat_lo_q;
	logic [3:0] lat_up_q;
	// A Port C pin that drives a chip select reads back its own drive, so it must not feed the arrays.
	// Port C address mux
	wire logic [2:0] portc_addr = portc_in & ~cfg_in.portc_pin_function_cfg;
	wire logic [3:0] up_pins = {upper_pin_in, portc_addr};

	// the latch follows while ALE is active and holds its last value after the trailing edge.
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			lat_lo_q <= PDC_ZERO16;
			lat_up_q <= 4'h0;
		end else if (ale_act) begin
			lat_lo_q <= {ad_hi_in, ad_lo_in};
			lat_up_q <= up_pins;
		end
	end

	wire logic lo_use_latch = mux_mode | cfg_in.nonmux_addr_latch_cfg;
	wire logic [15:0] lo_latched = ale_act ? {ad_hi_in, ad_lo_in} : lat_lo_q;
	// In 8-bit multiplexed mode the high pins carry address only.
	wire logic [15:0] lo_mux = (wide | ~mux_mode) ? lo_latched : {ad_hi_in, lo_latched[7:0]};
	wire logic [15:0] addr_lo = lo_use_latch ? lo_mux : {ad_hi_in, ad_lo_in};
	wire logic [3:0] addr_up = cfg_in.upper_addr_latch_cfg ? (ale_act ? up_pins : lat_up_q) : up_pins;

	// ==========================================================
	// Product-term arrays
	// ==========================================================
	// A19 reads as zero in the power-down setting, so no term can see the pin there.
	// the upper pin is a decoder input only in its address setting.
	wire logic a19_in = cfg_in.upper_pin_function_cfg & addr_up[3];
	wire logic power_down = ~cfg_in.upper_pin_function_cfg & upper_pin_in;
	// reset is applied after the arrays and never enters the vector.
	wire logic deselect = power_down | ~pad_reset_n_in | sys_rst_in;

	// Raw strobe pins enter the vector so that a term can qualify on read or write.
	// one shared input vector for both arrays
	wire logic [PDC_NIN-1:0] pad_vec = {ale_in, wr_rw_in, rd_e_in, page_inputs_in,
		a19_in, addr_up[2:0], addr_lo[PDC_ADDR_BASE +: PDC_ADDR_BITS]};
	logic [PDC_NTERMS-1:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < PDC_NTERMS; gi++) begin : g_term
			assign hit[gi] = terms_in[gi].en &
				~|((pad_vec ^ terms_in[gi].value) & terms_in[gi].care);
		end
	endgenerate

	logic [PDC_NCS_B-1:0] csb_hit;
	generate
		for (gi = 0; gi < PDC_NCS_B; gi++) begin : g_csb
			if (gi < PDC_NCS_WIDE) begin : g_wide
				assign csb_hit[gi] = |hit[PDC_T_CS_WIDE + gi*PDC_WIDE_TERMS +: PDC_WIDE_TERMS];
			end else begin : g_narrow
				assign csb_hit[gi] = |hit[PDC_T_CS_NARROW + (gi-PDC_NCS_WIDE)*PDC_NARROW_TERMS +: PDC_NARROW_TERMS];
			end
		end
	endgenerate

	wire logic [PDC_NBANK-1:0] bank_hit = hit[PDC_T_BANK +: PDC_NBANK];
	wire logic sram_hit = hit[PDC_T_SRAM];
	wire logic port_hit = hit[PDC_T_PORT];
	wire logic [PDC_NCS_C-1:0] csc_hit = hit[PDC_T_CS_PORTC +: PDC_NCS_C];
	wire logic tin_act = hit[PDC_T_TIN] & ~deselect;
	wire logic taout_act = hit[PDC_T_TAOUT] & ~deselect;
	// the data-out term carries the write qualifier, so it alone gates the drive.
	wire logic tdout_act = hit[PDC_T_TDOUT] & ~deselect;
	wire logic int_hit = (|bank_hit | sram_hit | port_hit) & ~deselect;

	// ==========================================================
	// Pin routing
	// ==========================================================
	wire logic track = cfg_in.porta_track_cfg & mux_mode;
	wire logic int_rd = int_hit & rd_act;
	wire logic nonmux16 = ~mux_mode & wide;
	pdc_pin8_t ad_lo_d;
	pdc_pin8_t ad_hi_d;
	pdc_pin8_t pa_d;
	pdc_pin8_t pb_d;

	always_comb begin
		ad_lo_d = '{o: PDC_ZERO8, oe: PDC_ZERO8};
		ad_hi_d = '{o: PDC_ZERO8, oe: PDC_ZERO8};
		pa_d = '{o: porta_gpio_dout_in, oe: porta_gpio_dir_in};
		// data path follows width and multiplexing
		if (mux_mode && int_rd) begin
			ad_lo_d = '{o: bus_rdata_in[7:0], oe: PDC_DESEL8};
			if (wide) begin
				ad_hi_d = '{o: bus_rdata_in[15:8], oe: PDC_DESEL8};
			end
		end
		if (!mux_mode) begin
			// Port A is the low data byte
			pa_d = '{o: bus_rdata_in[7:0], oe: {8{int_rd}}};
		end else if (track) begin
			// data out on write, otherwise floating
			pa_d = '{o: ad_lo_in, oe: {8{tdout_act}}};
			if (taout_act && ale_act) begin
				pa_d = '{o: ad_lo_in, oe: PDC_DESEL8};
			end
			// Port A level onto low host pins on read
			if (tin_act && rd_act) begin
				ad_lo_d = '{o: porta_in, oe: PDC_DESEL8};
			end
		end else begin
			// per-pin I/O or latched low address
			for (int i = 0; i < 8; i++) begin
				if (cfg_in.porta_pin_function_cfg[i]) begin
					pa_d.o[i] = lat_lo_q[i];
					pa_d.oe[i] = 1'b1;
				end
			end
		end
		if (nonmux16) begin
			// Port B is the high data byte
			pb_d = '{o: bus_rdata_in[15:8], oe: {8{int_rd}}};
		end else begin
			// Port B per-pin chip select or I/O
			for (int i = 0; i < 8; i++) begin
				pb_d.o[i] = cfg_in.portb_pin_function_cfg[i] ? portb_gpio_dout_in[i] : ~(csb_hit[i] & ~deselect);
				pb_d.oe[i] = cfg_in.portb_pin_function_cfg[i] ? portb_gpio_dir_in[i] : 1'b1;
			end
		end
	end

	// Write data comes from the pins that carry the data bus in this mode.
	wire logic [15:0] wdata_d = mux_mode ? {ad_hi_in, ad_lo_in} : {portb_in, porta_in};

	// ==========================================================
	// Output registers
	// ==========================================================
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			bank_selects_n_out <= PDC_DESEL8;
			sram_select_n_out <= 1'b1;
			port_block_select_n_out <= 1'b1;
			portb_chip_selects_n_out <= PDC_DESEL8;
			portc_chip_selects_n_out <= PDC_DESEL3;
			standby_out <= 1'b0;
			host_read_out <= 1'b0;
			host_write_out <= 1'b0;
			bus_wdata_out <= PDC_ZERO16;
			addr_out <= 20'h00000;
			ad_lo_out <= PDC_ZERO8;
			ad_lo_oe_out <= PDC_ZERO8;
			ad_hi_out <= PDC_ZERO8;
			ad_hi_oe_out <= PDC_ZERO8;
			porta_out <= PDC_ZERO8;
			porta_oe_out <= PDC_ZERO8;
			portb_out <= PDC_ZERO8;
			portb_oe_out <= PDC_ZERO8;
			// Port C rests at the deselected level, matching its chip select outputs.
			portc_out <= PDC_DESEL3;
			portc_oe_out <= PDC_ZERO3;
		end else begin
			// active-low sum-of-products outputs, gated by deselect
			bank_selects_n_out <= ~(bank_hit & {PDC_NBANK{~deselect}});
			sram_select_n_out <= ~(sram_hit & ~deselect);
			port_block_select_n_out <= ~(port_hit & ~deselect);
			portb_chip_selects_n_out <= ~(csb_hit & {PDC_NCS_B{~deselect}});
			portc_chip_selects_n_out <= ~(csc_hit & {PDC_NCS_C{~deselect}});
			standby_out <= power_down;
			host_read_out <= rd_act;
			host_write_out <= wr_act;
			if (wr_act) begin
				bus_wdata_out <= wide ? wdata_d : {PDC_ZERO8, wdata_d[7:0]};
			end
			addr_out <= {a19_in, addr_up[2:0], addr_lo};
			ad_lo_out <= ad_lo_d.o;
			ad_lo_oe_out <= ad_lo_d.oe;
			ad_hi_out <= ad_hi_d.o;
			ad_hi_oe_out <= ad_hi_d.oe;
			porta_out <= pa_d.o;
			porta_oe_out <= pa_d.oe;
			portb_out <= pb_d.o;
			portb_oe_out <= pb_d.oe;
			// Port C output only where set as chip select
			portc_out <= ~(csc_hit & {PDC_NCS_C{~deselect}});
			portc_oe_out <= cfg_in.portc_pin_function_cfg;
		end
	end

endmodule
`default_nettype wire

// ### rtl/pdc_pkg.sv
// Constants, types and term layout for the programmable address decoder block.
package pdc_pkg;

	// ==========================================================
	// Decoder input vector layout
	// ==========================================================
	localparam int PDC_NIN = 16;
	localparam int PDC_IN_ADDR_LO = 0;
	localparam int PDC_ADDR_BITS = 5;
	localparam int PDC_ADDR_BASE = 11;
	localparam int PDC_IN_UPPER = 5;
	localparam int PDC_IN_PAGE = 9;
	localparam int PDC_IN_RD = 13;
	localparam int PDC_IN_WR = 14;
	localparam int PDC_IN_ALE = 15;
	localparam int PDC_PAGE_BITS = 4;

	// ==========================================================
	// Product term indices
	// ==========================================================
	localparam int PDC_NBANK = 8;
	localparam int PDC_T_BANK = 0;
	localparam int PDC_T_SRAM = 8;
	localparam int PDC_T_PORT = 9;
	localparam int PDC_T_TIN = 10;
	localparam int PDC_T_TAOUT = 11;
	localparam int PDC_T_TDOUT = 12;
	localparam int PDC_T_CS_WIDE = 13;
	localparam int PDC_WIDE_TERMS = 4;
	localparam int PDC_T_CS_NARROW = 29;
	localparam int PDC_NARROW_TERMS = 2;
	localparam int PDC_T_CS_PORTC = 37;
	localparam int PDC_NTERMS = 40;
	localparam int PDC_NCS_WIDE = 4;
	localparam int PDC_NCS_B = 8;
	localparam int PDC_NCS_C = 3;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] PDC_DESEL8 = 8'hff;
	localparam logic [2:0] PDC_DESEL3 = 3'h7;
	localparam logic [7:0] PDC_ZERO8 = 8'h00;
	localparam logic [2:0] PDC_ZERO3 = 3'h0;
	localparam logic [15:0] PDC_ZERO16 = 16'h0000;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		PDC_STROBE_RDWR = 2'b00,
		PDC_STROBE_E = 2'b01,
		PDC_STROBE_DS = 2'b11
	} pdc_strobe_t;

	typedef struct packed {
		logic en;
		logic [PDC_NIN-1:0] care;
		logic [PDC_NIN-1:0] value;
	} pdc_term_t;

	typedef struct packed {
		logic bus_width_cfg;
		logic bus_mux_cfg;
		logic upper_pin_function_cfg;
		logic latch_strobe_polarity_cfg;
		logic [7:0] porta_pin_function_cfg;
		logic porta_track_cfg;
		logic upper_addr_latch_cfg;
		logic nonmux_addr_latch_cfg;
		pdc_strobe_t strobe_style_cfg;
		logic [7:0] portb_pin_function_cfg;
		logic [2:0] portc_pin_function_cfg;
	} pdc_cfg_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} pdc_pin8_t;

endpackage

// ### sim/pdc_decoder_monitor.sv
// Concurrent checks on the decoder block ports.
`timescale 1ns/100ps
`default_nettype none
module pdc_decoder_chk
	import pdc_pkg::*;
(
	input wire logic mclk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic pad_reset_n_in, // pad reset
	input wire pdc_cfg_t cfg_in, // config
	input wire logic rd_e_in, // read pin
	input wire logic wr_rw_in, // write pin
	input wire logic upper_pin_in, // upper pin
	input wire logic [7:0] bank_selects_n_out, // banks
	input wire logic sram_select_n_out, // sram
	input wire logic port_block_select_n_out, // ports
	input wire logic [7:0] portb_chip_selects_n_out, // cs 0-7
	input wire logic [2:0] portc_chip_selects_n_out, // cs 8-10
	input wire logic standby_out, // standby
	input wire logic host_read_out, // read
	input wire logic host_write_out, // write
	input wire logic [15:0] bus_wdata_out, // write data
	input wire logic [7:0] ad_lo_oe_out, // AD enable
	input wire logic [7:0] porta_oe_out, // A enable
	input wire logic [7:0] portb_out, // B drive
	input wire logic [7:0] portb_oe_out, // B enable
	input wire logic [2:0] portc_out, // C drive
	input wire logic [2:0] portc_oe_out // C enable
);
	// ==========================================================
	// Expected strobes
	// ==========================================================
	wire logic [1:0] style = cfg_in.strobe_style_cfg;
	wire logic strobe_on = (style == 2'b01) ? rd_e_in : !rd_e_in;
	wire logic exp_rd = (style == 2'b00) ? !rd_e_in : (style != 2'b10) && strobe_on && wr_rw_in;
	wire logic exp_wr = (style == 2'b00) ? !wr_rw_in : (style != 2'b10) && strobe_on && !wr_rw_in;
	wire logic pwr_down = !cfg_in.upper_pin_function_cfg && upper_pin_in;
	wire logic all_desel = &{bank_selects_n_out, sram_select_n_out, port_block_select_n_out,
		portb_chip_selects_n_out, portc_chip_selects_n_out};
	wire logic portb_cs_mode = !cfg_in.portb_pin_function_cfg[4] && !(cfg_in.bus_width_cfg && !cfg_in.bus_mux_cfg);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	// ==========================================================
	// Assertions
	// ==========================================================
	a_pad_reset_desel: assert property (!pad_reset_n_in |=> all_desel)
		else $error("select active after pad reset");
	a_power_down: assert property (pwr_down |=> all_desel && standby_out)
		else $error("power-down did not deselect");
	a_standby_clear: assert property (!pwr_down |=> !standby_out)
		else $error("standby without power-down");
	a_strobe_decode: assert property (1'b1 |=> host_read_out == $past(exp_rd) && host_write_out == $past(exp_wr))
		else $error("strobe decode wrong");
	a_narrow_wdata: assert property (!cfg_in.bus_width_cfg && exp_wr |=> bus_wdata_out[15:8] == 8'h00)
		else $error("upper data byte in 8-bit width");
	a_portc_oe_cfg: assert property (1'b1 |=> portc_oe_out == $past(cfg_in.portc_pin_function_cfg))
		else $error("port C enable wrong");
	a_portc_value: assert property (portc_out == portc_chip_selects_n_out)
		else $error("port C drive wrong");
	a_portb_cs_pin: assert property (portb_cs_mode |=> portb_oe_out[4] && portb_out[4] == portb_chip_selects_n_out[4])
		else $error("port B select pin wrong");
	a_track_release: assert property (!pad_reset_n_in && cfg_in.porta_track_cfg && cfg_in.bus_mux_cfg |=>
		porta_oe_out == 8'h00 && ad_lo_oe_out == 8'h00)
		else $error("track drive during pad reset");
endmodule
bind pdc_decoder pdc_decoder_chk u_chk (.*);
`default_nettype wire

// ### sim/pdc_host_model.sv
// Host bus model that drives strobes and address/data pins.
`timescale 1ns/100ps
`default_nettype none
module pdc_host_model
	import pdc_pkg::*;
(
	output var logic ale_out, // latch strobe
	output var logic rd_e_out, // read or strobe
	output var logic wr_rw_out, // write or status
	output var logic [7:0] ad_lo_out, // AD0-AD7
	output var logic [7:0] ad_hi_out // AD8-AD15
);
	initial begin
		ale_out = 1'b0;
		rd_e_out = 1'b1;
		wr_rw_out = 1'b1;
		ad_lo_out = 8'h00;
		ad_hi_out = 8'h00;
	end
	// ==========================================================
	// Pin coding
	// ==========================================================
	task automatic drive(input pdc_strobe_t st, input logic pol, input logic ale, input logic rd, input logic wr,
		input logic [15:0] ad);
		ale_out <= ale ^ pol;
		case (st)
			PDC_STROBE_RDWR: begin
				rd_e_out <= !rd;
				wr_rw_out <= !wr;
			end
			PDC_STROBE_E: begin
				rd_e_out <= rd | wr;
				wr_rw_out <= !wr;
			end
			default: begin
				rd_e_out <= !(rd | wr);
				wr_rw_out <= !wr;
			end
		endcase
		// Released low byte shows a changing pattern while the device may drive.
		ad_lo_out <= rd ? ~ad_lo_out : ad[7:0];
		ad_hi_out <= ad[15:8];
	endtask
endmodule
`default_nettype wire

// ### sim/pdc_testbench.sv
// Self-checking testbench for the address decoder block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pdc_pkg::*;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic pad_reset_n_in = 1'b1;
	pdc_cfg_t cfg_in = '0;
	pdc_term_t [PDC_NTERMS-1:0] terms_in = '0;
	logic upper_pin_in = 1'b0;
	logic [3:0] page_inputs_in = 4'h0;
	logic [7:0] porta_in = 8'h5a;
	logic [7:0] portb_in = 8'ha5;
	logic [2:0] portc_in = 3'h2;
	logic [15:0] bus_rdata_in = 16'h1234;
	wire logic ale_in, rd_e_in, wr_rw_in, sram_select_n_out, port_block_select_n_out, standby_out;
	wire logic host_read_out, host_write_out;
	wire logic [7:0] ad_lo_in, ad_hi_in, bank_selects_n_out, portb_chip_selects_n_out, ad_lo_out, ad_lo_oe_out;
	wire logic [7:0] porta_out, porta_oe_out;
	wire logic [2:0] portc_chip_selects_n_out;
	wire logic [15:0] bus_wdata_out;
	wire logic [19:0] addr_out;
	wire logic [7:0] ad_hi_oe_out;
	pdc_cfg_t cf_v = '0;
	pdc_term_t [PDC_NTERMS-1:0] tm_v = '0;
	logic [3:0] pg_v = 4'h0;
	logic up_v = 1'b0;
	logic [2:0] pc_v = 3'h2;
	logic rn_v = 1'b1;
	int n_mismatch = 0;
	int comparisons = 0;
	always #2 mclk_in = ~mclk_in;
	pdc_host_model host (.ale_out(ale_in), .rd_e_out(rd_e_in), .wr_rw_out(wr_rw_in), .ad_lo_out(ad_lo_in),
		.ad_hi_out(ad_hi_in));
	pdc_decoder dut (.mclk_in, .sys_rst_in, .pad_reset_n_in, .cfg_in, .terms_in, .ale_in, .rd_e_in, .wr_rw_in,
		.upper_pin_in, .page_inputs_in, .ad_lo_in, .ad_hi_in, .porta_in, .portb_in, .portc_in,
		.porta_gpio_dout_in(porta_in), .porta_gpio_dir_in(portb_in), .portb_gpio_dout_in(portb_in),
		.portb_gpio_dir_in(porta_in), .bus_rdata_in, .bank_selects_n_out, .sram_select_n_out,
		.port_block_select_n_out, .portb_chip_selects_n_out, .portc_chip_selects_n_out, .standby_out,
		.host_read_out, .host_write_out, .bus_wdata_out, .addr_out, .ad_lo_out, .ad_lo_oe_out, .ad_hi_out(),
		.ad_hi_oe_out, .porta_out, .porta_oe_out, .portb_out(), .portb_oe_out(), .portc_out(), .portc_oe_out());
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic term(input int idx, input logic [15:0] care, input logic [15:0] value);
		tm_v[idx] = {1'b1, care, value};
	endtask
	task automatic cyc(input logic ale, input logic rd, input logic wr, input logic [15:0] ad);
		@(posedge mclk_in);
		host.drive(cf_v.strobe_style_cfg, cf_v.latch_strobe_polarity_cfg, ale, rd, wr, ad);
		cfg_in <= cf_v;
		terms_in <= tm_v;
		page_inputs_in <= pg_v;
		upper_pin_in <= up_v;
		portc_in <= pc_v;
		pad_reset_n_in <= rn_v;
		@(posedge mclk_in);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge mclk_in);
		n_mismatch++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin : main
		int i;
		pdc_strobe_t styles [3] = '{PDC_STROBE_RDWR, PDC_STROBE_E, PDC_STROBE_DS};
		repeat (15) @(posedge mclk_in);
		#1;
		chk("banks in reset", 16'h00ff, bank_selects_n_out);
		chk("standby in reset", 16'h0, standby_out);
		@(posedge mclk_in);
		sys_rst_in <= 1'b0;
		for (i = 0; i < 8; i++) term(i, 16'h001f, 16'(i + 1));
		term(PDC_T_SRAM, 16'h001f, 16'h0009);
		term(PDC_T_PORT, 16'h001f, 16'h000a);
		term(PDC_T_CS_WIDE, 16'h001f, 16'h0009);
		for (i = 0; i < 8; i++) begin
			cyc(1'b0, 1'b1, 1'b0, {5'(i + 1), 11'h0});
			chk("bank select", 16'(8'(~(8'h01 << i))), bank_selects_n_out);
		end
		pg_v = 4'hf;
		cyc(1'b0, 1'b1, 1'b0, 16'h4800);
		chk("sram select", 16'h0, sram_select_n_out);
		chk("shared term", 16'h0, portb_chip_selects_n_out[0]);
		cyc(1'b0, 1'b1, 1'b0, 16'h5000);
		chk("port select", 16'h0, port_block_select_n_out);
		chk("sram miss", 16'h1, sram_select_n_out);
		rn_v = 1'b0;
		cyc(1'b0, 1'b1, 1'b0, 16'h4800);
		chk("sram in pad reset", 16'h1, sram_select_n_out);
		rn_v = 1'b1;
		up_v = 1'b1;
		cyc(1'b0, 1'b1, 1'b0, 16'h4800);
		chk("sram in power-down", 16'h1, sram_select_n_out);
		chk("standby", 16'h1, standby_out);
		cf_v.upper_pin_function_cfg = 1'b1;
		cyc(1'b0, 1'b1, 1'b0, 16'h4800);
		chk("sram with pin as input", 16'h0, sram_select_n_out);
		$display("test decode done");
		tm_v = '0;
		term(PDC_T_CS_WIDE + 3, 16'h1e00, 16'h0c00);
		term(PDC_T_CS_NARROW + 1, 16'h1e00, 16'h0a00);
		term(PDC_T_CS_PORTC, 16'h1e00, 16'h0e00);
		cf_v.portc_pin_function_cfg = 3'h1;
		for (i = 5; i < 8; i++) begin
			pg_v = 4'(i);
			cyc(1'b0, 1'b0, 1'b0, 16'h0000);
			chk("wide select", 16'(i != 6), portb_chip_selects_n_out[0]);
			chk("narrow select", 16'(i != 5), portb_chip_selects_n_out[4]);
			chk("port C select", 16'(i != 7), portc_chip_selects_n_out[0]);
		end
		$display("test chip selects done");
		for (i = 0; i < 3; i++) begin
			cf_v.strobe_style_cfg = styles[i];
			cf_v.bus_width_cfg = (i == 0);
			cyc(1'b0, 1'b1, 1'b0, 16'h0000);
			chk("read strobe", 16'h1, host_read_out);
			cyc(1'b0, 1'b0, 1'b1, 16'h0000);
			chk("write strobe", 16'h1, host_write_out);
			if (i == 0) chk("wide write data", 16'ha55a, bus_wdata_out);
		end
		$display("test strobes done");
		cf_v = '0;
		up_v = 1'b0;
		cf_v.bus_mux_cfg = 1'b1;
		cf_v.porta_track_cfg = 1'b1;
		tm_v = '0;
		term(PDC_T_TIN, 16'h001f, 16'h0001);
		term(PDC_T_TAOUT, 16'h001f, 16'h0002);
		term(PDC_T_TDOUT, 16'h401f, 16'h0003);
		cyc(1'b0, 1'b1, 1'b0, 16'h0800);
		chk("track read enable", 16'h00ff, ad_lo_oe_out);
		chk("track read data", 16'h005a, ad_lo_out);
		chk("high pins idle", 16'h0, ad_hi_oe_out);
		for (i = 0; i < 2; i++) begin
			cf_v.latch_strobe_polarity_cfg = 1'(i);
			cyc(1'b1, 1'b0, 1'b0, 16'h103c);
			chk("track address out", 16'h003c, porta_out);
			chk("track address enable", 16'h00ff, porta_oe_out);
		end
		cyc(1'b0, 1'b0, 1'b1, 16'h18c3);
		chk("track data out", 16'h00c3, porta_out);
		cyc(1'b0, 1'b0, 1'b0, 16'h2000);
		chk("track idle", 16'h0, porta_oe_out);
		rn_v = 1'b0;
		cyc(1'b1, 1'b0, 1'b0, 16'h103c);
		chk("track in pad reset", 16'h0, porta_oe_out);
		rn_v = 1'b1;
		cf_v.porta_track_cfg = 1'b0;
		cf_v.porta_pin_function_cfg = 8'hff;
		cf_v.upper_addr_latch_cfg = 1'b1;
		cyc(1'b1, 1'b0, 1'b0, 16'h0077);
		pc_v = 3'h5;
		cyc(1'b0, 1'b1, 1'b0, 16'h0000);
		chk("latched address", 16'h0077, porta_out);
		chk("low address", 16'h0077, addr_out[15:0]);
		chk("upper address", 16'h0002, addr_out[19:16]);
		cf_v.bus_mux_cfg = 1'b0;
		cf_v.nonmux_addr_latch_cfg = 1'b1;
		cyc(1'b1, 1'b0, 1'b0, 16'h1234);
		cyc(1'b0, 1'b0, 1'b0, 16'h5678);
		chk("held address", 16'h1234, addr_out[15:0]);
		$display("test track done");
		summarize();
	end
endmodule
`default_nettype wire
